// File: rtl/tps_defines.svh
// Offsets, bit positions, reset values and sizes of the transmit path status block
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// Register byte offsets on the APB window
`define TPS_OFF_CTRL 12'h240
`define TPS_OFF_STAT 12'h244
`define TPS_OFF_FLAGS 12'h248
`define TPS_OFF_EN 12'h24C
`define TPS_OFF_CFG 12'h250

// Reset values
`define TPS_RETRY_RST 8'hFF
`define TPS_WORD_ZERO 32'h0000_0000

// Control register fields
`define TPS_ACKFLUSH_BIT 16
`define TPS_RETRY_MSB 7

// Status register fields
`define TPS_VIDSEL_BIT 29
`define TPS_ACKERR_BIT 28
`define TPS_CODE_LSB 24
`define TPS_NODE_LSB 16
`define TPS_PKT_LSB 8
`define TPS_TCODE_LSB 4

// Event flag field, bits 27:23 of the flag and enable registers
`define TPS_NFLAGS 5
`define TPS_FLAG_LSB 23
`define TPS_FLAG_MSB 27

// Sizes
`define TPS_ACKQ_DEPTH 4
`define TPS_NBUF 8
`define TPS_MAX_VIDEO 5'h02

`endif

// File: rtl/tps_pkg.sv
// Types shared by the transmit path status block
package tps_pkg;
    typedef logic [31:0] tps_word_t;
    typedef logic [3:0] tps_ack_t;
    typedef logic [7:0] tps_bufsel_t;

    // Acknowledge codes that do not mean failure
    typedef enum logic [3:0] {
        TPS_ACK_COMPLETE = 4'h1,
        TPS_ACK_PENDING = 4'h2,
        TPS_ACK_BUSY_X = 4'h4,
        TPS_ACK_BUSY_A = 4'h5,
        TPS_ACK_BUSY_B = 4'h6
    } tps_ack_ok_t;

    // Index of each event inside the five-bit flag vector
    typedef enum logic [2:0] {
        TPS_FL_FLUSH0 = 3'b000,
        TPS_FL_ISO = 3'b001,
        TPS_FL_ACKRX = 3'b010,
        TPS_FL_LOST = 3'b011,
        TPS_FL_ASYNC = 3'b100
    } tps_flag_idx_t;
endpackage

// File: rtl/tps_flag_if.sv
// Set, clear and state of the sticky event flags
`timescale 1ns/10ps
`include "tps_defines.svh"
interface tps_flag_if;
    logic [`TPS_NFLAGS-1:0] set;
    logic [`TPS_NFLAGS-1:0] clr;
    logic [`TPS_NFLAGS-1:0] flags;
    modport ctl (output set, output clr, input flags);
    modport flg (input set, input clr, output flags);
endinterface

// File: rtl/tps_event_flags.sv
// Sticky event flags, set by hardware, cleared by software
`timescale 1ns/10ps
`include "tps_defines.svh"
module tps_event_flags (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Flag traffic
    tps_flag_if.flg fl
);
    import tps_pkg::*;

    logic [`TPS_NFLAGS-1:0] flags_q;

    genvar i;
    generate
        for (i = 0; i < `TPS_NFLAGS; i++) begin : g_flag
            // Set beats clear so an event in the clearing cycle is kept
            always_ff @(posedge clock) begin
                if (rst) begin
                    flags_q[i] <= 1'b0;
                end else if (fl.set[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (fl.clr[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign fl.flags = flags_q;
endmodule

// File: rtl/tps_ack_queue.sv
// Acknowledge queue: code storage, occupancy count, flush and overrun
`timescale 1ns/10ps
`include "tps_defines.svh"
module tps_ack_queue (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Producer side
    input wire logic push,
    input wire tps_pkg::tps_ack_t push_code,
    input wire logic flush,
    // Consumer side
    input wire logic pop,
    output tps_pkg::tps_ack_t head_code,
    output logic [2:0] count,
    output logic overrun
);
    import tps_pkg::*;

    tps_ack_t mem_q [`TPS_ACKQ_DEPTH];
    logic [1:0] wr_q;
    logic [1:0] rd_q;
    logic [2:0] cnt_q;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    assign full = (cnt_q == 3'(`TPS_ACKQ_DEPTH));
    assign empty = (cnt_q == 3'h0);
    // Pop first so a push into a full queue with a pop in the same cycle fits
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign overrun = push && full && !do_pop && !flush;

    genvar e;
    generate
        for (e = 0; e < `TPS_ACKQ_DEPTH; e++) begin : g_entry
            always_ff @(posedge clock) begin
                if (rst) begin
                    mem_q[e] <= 4'h0;
                end else if (do_push && !flush && wr_q == 2'(e)) begin
                    mem_q[e] <= push_code;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst || flush) begin
            wr_q <= 2'h0;
            rd_q <= 2'h0;
            cnt_q <= 3'h0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 2'h1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 2'h1;
            end
            cnt_q <= cnt_q + 3'(do_push) - 3'(do_pop);
        end
    end

    assign head_code = mem_q[rd_q];
    assign count = cnt_q;
endmodule

// File: rtl/tps_top.sv
// Transmit path status, event flags and their APB register window
// How it works
// - Flag bit 29 when a buffer feeds both videos or over two paths are selected.
// - Flag bit 28 when a returned acknowledge code signals failure.
// - Bits 27:24 show the acknowledge code the receiving node returned.
// - Streaming and broadcast packets get an internal ack-complete code unless a real acknowledge arrives in the same cycle.
// - Bits 21:16 show the destination node; meaningless for streaming packets.
// - Bits 15:8 show packet identification taken from the first header quadlet.
// - Bits 7:4 show the transmitted packet's tCode, read only.
// - Bits 2:0 count acknowledges held in the acknowledge queue.
// - Reserved bits ignore writes and read as zero.
// - Bit 27 flags retry exhaustion, error acknowledge or illegal async tCode.
// - Bit 26 flags an acknowledge queue overrun.
// - Bit 25 flags each acknowledge written into the queue.
// - Interrupt rises when any flag and its enable are both set.
// - Bit 24 flags an iso illegal tCode or a length mismatch.
// - Bit 23 flags a buffer-0 error flush, only with flush-on-error enabled.
// - Retry limit sits in control bits 7:0 and resets to all ones.
// - Writing one to control bit 16 empties the queue; it self clears.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "tps_defines.svh"
module tps_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire tps_pkg::tps_word_t pwdata,
    output tps_pkg::tps_word_t prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    // Interrupt
    output logic irq_q,
    // Transmit engine: packet done
    input wire logic tx_done,
    input wire tps_pkg::tps_word_t tx_header,
    input wire logic tx_no_ack,
    // Transmit engine: acknowledges
    input wire logic ack_valid,
    input wire tps_pkg::tps_ack_t ack_code,
    input wire logic ack_pop,
    output tps_pkg::tps_ack_t ack_head_q,
    // Transmit engine: retries and errors
    input wire logic retry_attempt,
    input wire logic [7:0] retry_num,
    input wire logic async_bad_tcode,
    input wire logic iso_bad_tcode,
    input wire logic iso_len_mismatch,
    input wire logic buf0_err_flush,
    output logic [7:0] async_retry_limit_q,
    output logic flush_on_error_enable_q,
    // Video path selection
    input wire tps_pkg::tps_bufsel_t vid_sel_a,
    input wire tps_pkg::tps_bufsel_t vid_sel_b
);
    import tps_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tps_flag_if fl ();

    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    tps_word_t rd_mux;
    logic [`TPS_NFLAGS-1:0] en_q;
    logic ack_flush_q;
    logic vid_conflict_q;
    logic ack_err_q;
    tps_ack_t ack_code_q;
    logic [5:0] node_q;
    logic [7:0] packet_ident_field_q;
    logic [3:0] tcode_q;
    logic q_push;
    tps_ack_t q_code;
    tps_ack_t q_head;
    logic [2:0] q_count;
    logic q_overrun;
    logic vid_conflict;
    logic push_err;
    logic retry_done;
    tps_word_t status_word;

    function automatic logic [4:0] tps_popcount(input tps_bufsel_t v);
        logic [4:0] n;
        n = 5'h00;
        for (int b = 0; b < `TPS_NBUF; b++) begin
            n = n + 5'(v[b]);
        end
        return n;
    endfunction

    function automatic logic tps_ack_bad(input tps_ack_t c);
        return !(c inside {TPS_ACK_COMPLETE, TPS_ACK_PENDING, TPS_ACK_BUSY_X,
                           TPS_ACK_BUSY_A, TPS_ACK_BUSY_B});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer in the second access cycle

    assign acc = psel && penable && pready_q;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign mapped = paddr inside {`TPS_OFF_CTRL, `TPS_OFF_STAT, `TPS_OFF_FLAGS,
                                  `TPS_OFF_EN, `TPS_OFF_CFG};

    always_ff @(posedge clock) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `TPS_WORD_ZERO;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_mux : `TPS_WORD_ZERO;
        end
    end

    // Unlisted and reserved bits read as zero
    always_comb begin
        rd_mux = `TPS_WORD_ZERO;
        unique case (paddr)
            `TPS_OFF_CTRL: begin
                rd_mux[`TPS_RETRY_MSB:0] = async_retry_limit_q;
            end
            `TPS_OFF_STAT: begin
                rd_mux = status_word;
            end
            `TPS_OFF_FLAGS: begin
                rd_mux[`TPS_FLAG_MSB:`TPS_FLAG_LSB] = fl.flags;
            end
            `TPS_OFF_EN: begin
                rd_mux[`TPS_FLAG_MSB:`TPS_FLAG_LSB] = en_q;
            end
            `TPS_OFF_CFG: begin
                rd_mux[0] = flush_on_error_enable_q;
            end
            default: begin
                rd_mux = `TPS_WORD_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers

    always_ff @(posedge clock) begin
        if (rst) begin
            async_retry_limit_q <= `TPS_RETRY_RST;
        end else if (wr && paddr == `TPS_OFF_CTRL) begin
            async_retry_limit_q <= pwdata[`TPS_RETRY_MSB:0];
        end
    end

    // Flush strobe lives one cycle and always reads back as zero
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_flush_q <= 1'b0;
        end else begin
            ack_flush_q <= wr && paddr == `TPS_OFF_CTRL && pwdata[`TPS_ACKFLUSH_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            en_q <= '0;
            flush_on_error_enable_q <= 1'b0;
        end else if (wr && paddr == `TPS_OFF_EN) begin
            en_q <= pwdata[`TPS_FLAG_MSB:`TPS_FLAG_LSB];
        end else if (wr && paddr == `TPS_OFF_CFG) begin
            flush_on_error_enable_q <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge queue

    // A real acknowledge wins over an internal one in the same cycle
    assign q_push = ack_valid || (tx_done && tx_no_ack);
    assign q_code = ack_valid ? ack_code : TPS_ACK_COMPLETE;

    tps_ack_queue u_ackq (
        .clock(clock),
        .rst(rst),
        .push(q_push),
        .push_code(q_code),
        .flush(ack_flush_q),
        .pop(ack_pop),
        .head_code(q_head),
        .count(q_count),
        .overrun(q_overrun)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_head_q <= 4'h0;
        end else begin
            ack_head_q <= q_head;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status capture

    assign vid_conflict = (|(vid_sel_a & vid_sel_b))
        || ((tps_popcount(vid_sel_a) + tps_popcount(vid_sel_b)) > `TPS_MAX_VIDEO);
    assign push_err = q_push && tps_ack_bad(q_code);

    always_ff @(posedge clock) begin
        if (rst) begin
            vid_conflict_q <= 1'b0;
        end else begin
            vid_conflict_q <= vid_conflict;
        end
    end

    // Code and error bit follow the most recent acknowledge
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_code_q <= 4'h0;
            ack_err_q <= 1'b0;
        end else if (q_push) begin
            ack_code_q <= q_code;
            ack_err_q <= push_err;
        end
    end

    // Streaming packets carry no destination node there, so the node field is meaningless for them
    always_ff @(posedge clock) begin
        if (rst) begin
            node_q <= 6'h00;
            packet_ident_field_q <= 8'h00;
            tcode_q <= 4'h0;
        end else if (tx_done) begin
            node_q <= tx_header[21:16];
            packet_ident_field_q <= tx_header[15:8];
            tcode_q <= tx_header[7:4];
        end
    end

    always_comb begin
        status_word = `TPS_WORD_ZERO;
        status_word[`TPS_VIDSEL_BIT] = vid_conflict_q;
        status_word[`TPS_ACKERR_BIT] = ack_err_q;
        status_word[`TPS_CODE_LSB+:4] = ack_code_q;
        status_word[`TPS_NODE_LSB+:6] = node_q;
        status_word[`TPS_PKT_LSB+:8] = packet_ident_field_q;
        status_word[`TPS_TCODE_LSB+:4] = tcode_q;
        status_word[2:0] = q_count;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags and interrupt

    assign retry_done = retry_attempt && (retry_num >= async_retry_limit_q);

    always_comb begin
        fl.set = '0;
        fl.set[TPS_FL_ASYNC] = retry_done || push_err || async_bad_tcode;
        fl.set[TPS_FL_LOST] = q_overrun;
        fl.set[TPS_FL_ACKRX] = q_push && !q_overrun;
        fl.set[TPS_FL_ISO] = iso_bad_tcode || iso_len_mismatch;
        fl.set[TPS_FL_FLUSH0] = buf0_err_flush && flush_on_error_enable_q;
    end

    // Clear only what the read returned, so a flag set after sampling survives
    always_comb begin
        fl.clr = '0;
        if (rd && paddr == `TPS_OFF_FLAGS) begin
            fl.clr = prdata_q[`TPS_FLAG_MSB:`TPS_FLAG_LSB];
        end else if (wr && paddr == `TPS_OFF_FLAGS) begin
            fl.clr = pwdata[`TPS_FLAG_MSB:`TPS_FLAG_LSB];
        end
    end

    tps_event_flags u_flags (
        .clock(clock),
        .rst(rst),
        .fl(fl)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(fl.flags & en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence flush_write_s;
        wr && paddr == `TPS_OFF_CTRL && pwdata[`TPS_ACKFLUSH_BIT];
    endsequence

    sequence flags_read_s;
        rd && paddr == `TPS_OFF_FLAGS;
    endsequence

    vid_conflict_a: assert property (@(posedge clock) disable iff (rst)
        vid_conflict |=> vid_conflict_q)
        else $error("video conflict not reported");
    ack_error_a: assert property (@(posedge clock) disable iff (rst)
        push_err |=> ack_err_q && status_word[`TPS_ACKERR_BIT])
        else $error("failed acknowledge not flagged");
    ack_code_a: assert property (@(posedge clock) disable iff (rst)
        ack_valid |=> ack_code_q == $past(ack_code))
        else $error("acknowledge code not captured");
    internal_complete_a: assert property (@(posedge clock) disable iff (rst)
        tx_done && tx_no_ack && !ack_valid |=> ack_code_q == TPS_ACK_COMPLETE && !ack_err_q)
        else $error("internal complete code missing");
    header_capture_a: assert property (@(posedge clock) disable iff (rst)
        tx_done |=> packet_ident_field_q == $past(tx_header[15:8]) && node_q == $past(tx_header[21:16]))
        else $error("header fields not captured");
    tcode_field_a: assert property (@(posedge clock) disable iff (rst)
        tx_done |=> status_word[7:4] == $past(tx_header[7:4]))
        else $error("tcode field wrong");
    count_track_a: assert property (@(posedge clock) disable iff (rst)
        q_push && !ack_pop && !ack_flush_q && q_count < 3'(`TPS_ACKQ_DEPTH)
        |=> q_count == $past(q_count) + 3'h1)
        else $error("ack count did not advance");
    // Bits 23 and 3 are live in the flag and control words, so only the status word is held to them
    reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
        pready_q |-> prdata_q[31:30] == 2'b00
            && (paddr != `TPS_OFF_STAT || (prdata_q[23:22] == 2'b00 && prdata_q[3] == 1'b0)))
        else $error("reserved bits read nonzero");

    async_error_a: assert property (@(posedge clock) disable iff (rst)
        retry_done || push_err || async_bad_tcode |=> fl.flags[TPS_FL_ASYNC])
        else $error("async transmit error not flagged");
    overrun_a: assert property (@(posedge clock) disable iff (rst)
        q_overrun |=> fl.flags[TPS_FL_LOST] && q_count == 3'(`TPS_ACKQ_DEPTH))
        else $error("overrun not flagged");
    ack_arrived_a: assert property (@(posedge clock) disable iff (rst)
        q_push && !q_overrun |=> fl.flags[TPS_FL_ACKRX])
        else $error("ack arrival not flagged");

    irq_follow_a: assert property (@(posedge clock) disable iff (rst)
        fl.flags[TPS_FL_ACKRX] && en_q[TPS_FL_ACKRX] |=> irq_q)
        else $error("interrupt missing");

    iso_error_a: assert property (@(posedge clock) disable iff (rst)
        iso_bad_tcode || iso_len_mismatch |=> fl.flags[TPS_FL_ISO])
        else $error("iso error not flagged");

    flush_gate_a: assert property (@(posedge clock) disable iff (rst)
        !fl.flags[TPS_FL_FLUSH0] && !flush_on_error_enable_q |=> !fl.flags[TPS_FL_FLUSH0])
        else $error("flush flag set while disabled");

    retry_reset_a: assert property (@(posedge clock)
        $fell(rst) |-> async_retry_limit_q == `TPS_RETRY_RST)
        else $error("retry limit reset value wrong");

    ack_flush_a: assert property (@(posedge clock) disable iff (rst)
        flush_write_s |=> ack_flush_q ##1 q_count == 3'h0 && !ack_flush_q)
        else $error("ack queue not flushed");

    read_clear_a: assert property (@(posedge clock) disable iff (rst)
        flags_read_s and (fl.set == '0) |=> (fl.flags & $past(prdata_q[27:23])) == '0)
        else $error("read did not clear returned flags");

endmodule

// File: testbench/tps_ack_node.sv
// Remote node model: returns one acknowledge code per request after a chosen delay
`timescale 1ns/10ps
module tps_ack_node (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request from the bench
    input wire logic req,
    input wire tps_pkg::tps_ack_t req_code,
    input wire logic [1:0] req_wait,
    // Acknowledge towards the device
    output logic ack_valid,
    output tps_pkg::tps_ack_t ack_code
);
    import tps_pkg::*;
    int left;
    tps_ack_t held;
    ////////////////////
    // Between answers the code lines toggle, so a stale code is never mistaken for a fresh one
    always_ff @(posedge clock) begin
        if (rst) begin
            left <= -1;
            ack_valid <= 1'b0;
            ack_code <= 4'h0;
        end else if (req) begin
            left <= int'(req_wait);
            held <= req_code;
            ack_valid <= 1'b0;
            ack_code <= ~ack_code;
        end else if (left == 0) begin
            left <= -1;
            ack_valid <= 1'b1;
            ack_code <= held;
        end else begin
            left <= (left > 0) ? left - 1 : -1;
            ack_valid <= 1'b0;
            ack_code <= ~ack_code;
        end
    end
endmodule

// File: testbench/test_tx_path_status_events.sv
// Self-checking bench for the transmit path status block
`timescale 1ns/10ps
module test_tx_path_status_events;
    import tps_pkg::*;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tx_done = 0, tx_no_ack = 0, ack_pop = 0;
    logic retry_attempt = 0, async_bad_tcode = 0, iso_bad_tcode = 0, iso_len_mismatch = 0, buf0_err_flush = 0;
    logic req = 0, ack_valid, pready_q, pslverr_q, irq_q, flush_on_error_enable_q, err;
    logic [11:0] paddr = 0;
    logic [7:0] retry_num = 0, async_retry_limit_q;
    logic [1:0] rwait = 0;
    tps_word_t pwdata = 0, tx_header = 0, prdata_q, rd;
    tps_ack_t ack_code, ack_head_q, rcode = 0;
    tps_bufsel_t vid_sel_a = 0, vid_sel_b = 0;
    int n_mismatch = 0, n_compared = 0, m_code = 0, m_err = 0, m_node = 0, m_pkt = 0, m_tc = 0;
    int m_vid = 0, m_fl = 0, m_en = 0;
    int q[$];
    int vid_tab[4] = '{16'h0102, 16'h0101, 16'h0304, 16'h0000};
    int vid_exp[4] = '{0, 1, 1, 0};
    always #5 clock = ~clock;
    tps_top i_tps_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .irq_q(irq_q), .tx_done(tx_done), .tx_header(tx_header), .tx_no_ack(tx_no_ack),
        .ack_valid(ack_valid), .ack_code(ack_code), .ack_pop(ack_pop), .ack_head_q(ack_head_q),
        .retry_attempt(retry_attempt), .retry_num(retry_num), .async_bad_tcode(async_bad_tcode),
        .iso_bad_tcode(iso_bad_tcode), .iso_len_mismatch(iso_len_mismatch), .buf0_err_flush(buf0_err_flush),
        .async_retry_limit_q(async_retry_limit_q), .flush_on_error_enable_q(flush_on_error_enable_q),
        .vid_sel_a(vid_sel_a), .vid_sel_b(vid_sel_b));
    tps_ack_node i_tps_ack_node (.clock(clock), .rst(rst), .req(req), .req_code(rcode), .req_wait(rwait),
        .ack_valid(ack_valid), .ack_code(ack_code));
    ////////////////////
    task chk(input tps_word_t seen, input tps_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Holds the request until pready is seen at an edge; one idle edge keeps back-to-back calls clean
    task apb(input logic wr, input logic [11:0] a, input tps_word_t d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // No cycle count is assumed here; only the watchdog ends a wait
        do begin
            @(posedge clock);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    function automatic tps_word_t stat_exp();
        return {2'b00, m_vid[0], m_err[0], m_code[3:0], 2'b00, m_node[5:0], m_pkt[7:0], m_tc[3:0], 1'b0,
            3'(q.size())};
    endfunction
    task m_push(input int c);
        m_code = c;
        m_err = !(c inside {1, 2, 4, 5, 6});
        if (m_err) m_fl |= 1 << 27;
        if (q.size() == 4) m_fl |= 1 << 26;
        else begin
            q.push_back(c);
            m_fl |= 1 << 25;
        end
    endtask
    task check_all();
        chk({31'b0, irq_q}, {31'b0, (m_fl & m_en) != 0});
        apb(1'b0, 12'h244, 0);
        chk(rd, stat_exp());
        apb(1'b0, 12'h248, 0);
        chk(rd, m_fl);
        m_fl = 0;
    endtask
    task ev(input int k);
        case (k)
            0: async_bad_tcode <= 1'b1;
            1: iso_bad_tcode <= 1'b1;
            2: iso_len_mismatch <= 1'b1;
            3: buf0_err_flush <= 1'b1;
            default: retry_attempt <= 1'b1;
        endcase
        @(posedge clock);
        {async_bad_tcode, iso_bad_tcode, iso_len_mismatch, buf0_err_flush, retry_attempt} <= 5'b0;
        repeat (3) @(posedge clock);
    endtask
    task node_ack(input int c, input int w);
        req <= 1'b1;
        rcode <= 4'(c);
        rwait <= 2'(w);
        @(posedge clock);
        req <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    task pkt(input logic no_ack);
        tx_header <= $urandom;
        tx_done <= 1'b1;
        tx_no_ack <= no_ack;
        @(posedge clock);
        tx_done <= 1'b0;
        tx_no_ack <= 1'b0;
        m_node = tx_header[21:16];
        m_pkt = tx_header[15:8];
        m_tc = tx_header[7:4];
        if (no_ack) m_push(1);
        repeat (3) @(posedge clock);
    endtask
    ////////////////////
    initial begin
        #100us;
        n_mismatch++;
        conclude();
    end
    initial begin
        rd = $urandom(20);
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(async_retry_limit_q, 32'h0000_00FF);
        check_all();
        apb(1'b0, 12'h2FC, 0);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, 12'h244, 32'hFFFF_FFFF);
        check_all();
        for (int i = 0; i < 4; i++) begin
            {vid_sel_a, vid_sel_b} <= 16'(vid_tab[i]);
            m_vid = vid_exp[i];
            repeat (3) @(posedge clock);
            check_all();
        end
        pkt(1'b0);
        check_all();
        pkt(1'b1);
        check_all();
        // Every code once; the enable alternates so masked flags must stay quiet
        for (int c = 0; c < 16; c++) begin
            m_en = (c % 2) ? 32'h0200_0000 : 32'h0800_0000;
            apb(1'b1, 12'h24C, m_en);
            if (q.size() == 3) begin
                chk(ack_head_q, q[0]);
                ack_pop <= 1'b1;
                @(posedge clock);
                ack_pop <= 1'b0;
                void'(q.pop_front());
            end
            node_ack(c, $urandom_range(3));
            m_push(c);
            check_all();
        end
        node_ack(1, 0);
        m_push(1);
        node_ack(1, 3);
        m_push(1);
        check_all();
        apb(1'b1, 12'h240, 32'h0001_00FF);
        q.delete();
        repeat (2) @(posedge clock);
        check_all();
        apb(1'b0, 12'h240, 0);
        chk(rd, 32'h0000_00FF);
        apb(1'b1, 12'h240, 32'h0000_0003);
        chk(async_retry_limit_q, 32'h0000_0003);
        retry_num <= 8'h02;
        ev(4);
        check_all();
        retry_num <= 8'h03;
        ev(4);
        m_fl |= 1 << 27;
        check_all();
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, 12'h250, f);
            chk(flush_on_error_enable_q, f);
            for (int k = 0; k < 4; k++) begin
                ev(k);
                m_fl |= (k == 0) ? 1 << 27 : (k == 3) ? f << 23 : 1 << 24;
                check_all();
            end
        end
        conclude();
    end
endmodule
